// ===== rtl/wwd_pkg.sv
package wwd_pkg;
    // Register map: one byte-wide control register
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h0C;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h7F;
    // Field positions inside watchdog_control
    localparam int ARM_BIT_POS = 7;
    localparam int COUNT_TOP_BIT_POS = 6;
    localparam int COUNT_WIDTH = 7;
    // Count value at which the top bit is about to fall
    localparam logic [6:0] COUNT_FALL_FROM = 7'h40;
    // Machine cycles per decrement
    localparam int PRESCALE_CYCLES = 49152;
    // Wake-up delay in CPU clocks after halt ends on an interrupt
    localparam int WAKE_DELAY_CYCLES = 4096;
    // Reset pulse: typical low time and the CPU clock it was sized for
    localparam int RESET_PULSE_NS = 500;
    localparam int CPU_REF_MHZ = 8;
    localparam int CLK_PERIOD_NS = 4;
    // Pulse length at the real clock: a typical time, so rounded down, at least one
    localparam int RESET_PULSE_CYCLES_RAW = RESET_PULSE_NS / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_CYCLES_RAW < 1) ? 1 : RESET_PULSE_CYCLES_RAW;
    // Read data for an unmapped address
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ===== rtl/wwd_prescaler.sv
// Divider that holds while run_i is low, giving one tick per full prescale period
module wwd_prescaler #(
    parameter int DIVIDE = 49152
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic run_i,
    input wire logic restart_i,
    output logic tick_o
);
    localparam int CW = $clog2(DIVIDE);

    // Elaboration check: a divider of one or less has no meaning
    initial begin
        if (DIVIDE < 2) begin
            $error("wwd_prescaler: DIVIDE must be at least 2");
        end
    end

    logic [CW-1:0] count; // Cycles seen in this period
    logic [CW-1:0] next_count;
    logic tick; // Registered terminal pulse
    logic next_tick;

    // Next-state: hold while stopped, wrap at the end of the period
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (restart_i) begin
            next_count = '0;
        end else if (run_i) begin
            if (count == CW'(DIVIDE - 1)) begin
                next_count = '0;
                next_tick = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign tick_o = tick;
endmodule

// ===== rtl/wwd_top.sv
// Overview of operation
// R1 - Decrement count every 49152 machine cycles
// R2 - Armed, count 40h to 3Fh resets
// R3 - Software rewrites C0h to FFh periodically
// R4 - Sixty-four programmable timeout steps
// R5 - Arm bit sticky, only reset clears
// R6 - Armed write with top bit clear resets
// R7 - Halt stops counting and blocks timeout resets; an armed write with top bit clear still resets
// R8 - Resume 4096 clocks after interrupt wake
// R9 - Control register resets to 7Fh
// R10 - Control at 0Ch: arm plus count
// R11 - Software refreshes before entering halt
// R12 - Reset pulse from fixed cycle count
//
// The plain strobed port was decided locally.
module wwd_top #(
    parameter int PRESCALE = wwd_pkg::PRESCALE_CYCLES,
    parameter int WAKE_DELAY = wwd_pkg::WAKE_DELAY_CYCLES
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic halt_i,
    input wire logic wake_irq_i,
    output logic sys_reset_n_o,
    output logic armed_o
);
    // Width of the wake-up delay counter
    // Sized from the delay itself so a shortened delay costs fewer flops
    localparam int WW = $clog2(WAKE_DELAY + 1);
    // Width of the reset pulse counter
    // The pulse count is fixed, so this width never changes with parameters
    localparam int PW = $clog2(wwd_pkg::RESET_PULSE_CYCLES + 1);

    // Elaboration check on the shortenable counts
    initial begin
        if (PRESCALE < 2 || WAKE_DELAY < 1) begin
            $error("wwd_top: PRESCALE must be >= 2 and WAKE_DELAY >= 1");
        end
    end

    // Halt sequencing states
    // RUN counts, HALTED stops the prescaler and the decrements, WAKING waits out the restart delay
    // Code 2'b11 is unused and falls back to RUN through the default branch
    typedef enum logic [1:0] {
        // Normal operation, prescaler running
        WWD_RUN = 2'b00,
        // Oscillator stopped, no counting and no timeout
        WWD_HALTED = 2'b01,
        // Woken by an interrupt, still frozen until the delay ends
        WWD_WAKING = 2'b10
    } wwd_state_t;

    // Pin-level inputs are brought in through two flops
    // Only the second flop of each pair is read by logic
    logic halt_s1; // Halt, first stage
    logic halt_s2; // Halt, safe to use
    logic wake_s1; // Wake-up, first stage
    logic wake_s2; // Wake-up, safe to use

    // Control register fields
    logic arm; // Sticky activation
    logic [6:0] count; // Decrementing timer
    logic [6:0] next_count; // Timer after this edge
    logic next_arm; // Activation after this edge
    // Halt sequencer state and its next value
    wwd_state_t state;
    wwd_state_t next_state;
    // Cycles left before counting resumes after a wake-up
    logic [WW-1:0] wake_cnt;
    logic [WW-1:0] next_wake_cnt;
    // Cycles left in the current reset pulse
    logic [PW-1:0] pulse_cnt;
    logic [PW-1:0] next_pulse_cnt;
    // Registered read data
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    // Reset line towards the system, low while a pulse runs
    logic rst_out_n;
    logic next_rst_out_n;
    logic fire; // Reset request this cycle
    logic tick; // One-cycle decrement strobe from the prescaler
    logic counting; // Prescaler may advance
    logic wr_hit; // Write aimed at the control register

    // Synchronisers for halt and wake-up lines
    // Both lines come from outside this clock, so metastability must settle first
    // The cost is two cycles of latency on entering and leaving halt
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            halt_s1 <= 1'b0;
            halt_s2 <= 1'b0;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            halt_s1 <= halt_i;
            halt_s2 <= halt_s1;
            wake_s1 <= wake_irq_i;
            wake_s2 <= wake_s1;
        end
    end

    // Counting only in run state and never during an output pulse
    // R7 halt stops count
    assign counting = (state == WWD_RUN) && rst_out_n;

    // R1 prescaled decrement tick
    // The prescaler keeps its phase across halt, so a wake-up does not
    // grant a full fresh period before the next decrement
    // Refreshing the register does not restart it either
    wwd_prescaler #(
        .DIVIDE(PRESCALE)
    ) u_prescaler (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .run_i(counting),
        .restart_i(1'b0),
        .tick_o(tick)
    );

    // R10 address decode
    assign wr_hit = wr_i && (addr_i == wwd_pkg::WATCHDOG_CONTROL_ADDR);

    // Halt sequencing: stop on halt, wait out the wake delay on interrupt
    always_comb begin
        next_state = state;
        next_wake_cnt = wake_cnt;
        case (state)
            WWD_RUN: begin
                // Enter halt as soon as the synchronised line is high
                if (halt_s2) begin
                    next_state = WWD_HALTED;
                end
            end
            WWD_HALTED: begin
                // R8 wake delay start
                if (wake_s2) begin
                    next_state = WWD_WAKING;
                    next_wake_cnt = WW'(WAKE_DELAY - 1);
                end
            end
            WWD_WAKING: begin
                // R8 resume after delay
                if (wake_cnt == '0) begin
                    // Delay spent: counting resumes next cycle
                    next_state = WWD_RUN;
                end else begin
                    // Still waiting for the oscillator to settle
                    next_wake_cnt = wake_cnt - 1'b1;
                end
            end
            // Unused code: recover to normal operation
            default: begin
                next_state = WWD_RUN;
            end
        endcase
    end

    // Halt sequencer registers; reset leaves halt and clears the delay
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= WWD_RUN;
            wake_cnt <= '0;
        end else begin
            state <= next_state;
            wake_cnt <= next_wake_cnt;
        end
    end

    // Control register update; a software write beats a same-cycle tick
    always_comb begin
        next_arm = arm;
        next_count = count;
        fire = 1'b0;
        if (wr_hit) begin
            // R5 arm set only
            next_arm = arm | wdata_i[wwd_pkg::ARM_BIT_POS];
            // R4 delay steps loaded
            next_count = wdata_i[wwd_pkg::COUNT_WIDTH-1:0];
            // R6 forced software reset
            if (next_arm && !wdata_i[wwd_pkg::COUNT_TOP_BIT_POS]) begin
                fire = 1'b1;
            end
        end else if (tick) begin
            // Plain decrement; the count wraps through zero when disarmed
            // A disarmed timer still runs so software can read it as a clock
            next_count = count - 1'b1;
            // R2 top bit falls
            if (arm && count == wwd_pkg::COUNT_FALL_FROM) begin
                fire = 1'b1;
            end
        end
    end

    // Arm and count registers; R9 reset value 7Fh
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arm <= wwd_pkg::WATCHDOG_CONTROL_RESET[wwd_pkg::ARM_BIT_POS];
            count <= wwd_pkg::WATCHDOG_CONTROL_RESET[wwd_pkg::COUNT_WIDTH-1:0];
        end else begin
            arm <= next_arm;
            count <= next_count;
        end
    end

    // Reset pulse generator; the pulse resets the block via the system reset
    // R12 fixed pulse count
    always_comb begin
        next_pulse_cnt = pulse_cnt;
        next_rst_out_n = rst_out_n;
        // A request during a running pulse is dropped, not queued
        if (fire && rst_out_n) begin
            // Start a pulse; the count includes the first low cycle
            next_pulse_cnt = PW'(wwd_pkg::RESET_PULSE_CYCLES - 1);
            next_rst_out_n = 1'b0;
        end else if (!rst_out_n) begin
            if (pulse_cnt == '0) begin
                next_rst_out_n = 1'b1;
            end else begin
                next_pulse_cnt = pulse_cnt - 1'b1;
            end
        end
    end

    // Pulse registers; the line idles high
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_cnt <= '0;
            rst_out_n <= 1'b1;
        end else begin
            pulse_cnt <= next_pulse_cnt;
            rst_out_n <= next_rst_out_n;
        end
    end

    // Read port: data valid the cycle after the strobe, zero otherwise
    always_comb begin
        // Idle data is zero so a bus OR of several slaves stays clean
        next_rdata = 8'h00;
        if (rd_i) begin
            // R10 control readback
            if (addr_i == wwd_pkg::WATCHDOG_CONTROL_ADDR) begin
                next_rdata = {arm, count};
            end else begin
                // Nothing else lives in this block
                next_rdata = wwd_pkg::UNMAPPED_READ;
            end
        end
    end

    // Read data register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Outputs come straight from flip-flops
    // Read data
    assign rdata_o = rdata;
    // The system must answer this line with its own reset; the block
    // does not clear itself, it only freezes while the line is low
    assign sys_reset_n_o = rst_out_n;
    // Activation level for status use
    assign armed_o = arm;
endmodule

// ===== sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PRE = 16;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic halt_i = 1'b0;
    logic wake_irq_i = 1'b0;
    logic [7:0] rdata_o;
    logic sys_reset_n_o;
    logic armed_o;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] tv [2] = '{8'hC0, 8'hFF};
    int n;
    int k;
    int fail_count = 0;
    int num_checks = 0;
    always #2 clk_i = ~clk_i;
    // Short prescale and wake delay keep the run brief
    wwd_top #(.PRESCALE(PRE), .WAKE_DELAY(8)) uut (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .halt_i, .wake_irq_i, .sys_reset_n_o, .armed_o);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    // Bounded wait for the reset line to reach a level
    task automatic wait_sys(input logic lvl, output int c);
        c = 0;
        while (sys_reset_n_o !== lvl && c < 1100) begin
            @(posedge clk_i);
            #1;
            c++;
        end
    endtask
    task automatic do_rst();
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        do_rst();
        rd(8'h0C, v);
        chk(v, 8'h7F);
        rd(8'h0D, v);
        chk(v, 8'h00);
        wr(8'h0D, 8'h80);
        chk({6'h00, armed_o, sys_reset_n_o}, 8'h01);
        wr(8'h0C, 8'h45);
        chk({7'h00, armed_o}, 8'h00);
        // Reads exactly 64 cycles apart see four decrements
        rd(8'h0C, v);
        repeat (62) @(posedge clk_i);
        rd(8'h0C, w);
        chk(w, v - 8'h04);
        wr(8'h0C, 8'hC5);
        wr(8'h0C, 8'h45);
        rd(8'h0C, v);
        chk(v & 8'hF0, 8'hC0);
        do_rst();
        chk({7'h00, armed_o}, 8'h00);
        wr(8'h0C, 8'h80);
        chk({6'h00, armed_o, sys_reset_n_o}, 8'h02);
        wait_sys(1'b1, n);
        do_rst();
        // Shortest and longest programmed timeouts
        foreach (tv[i]) begin
            wr(8'h0C, tv[i]);
            wait_sys(1'b0, n);
            k = int'(tv[i][5:0]) + 1;
            chk({7'h00, n >= (k - 1) * PRE && n <= k * PRE + 3}, 8'h01);
            wait_sys(1'b1, n);
            chk(8'(n), 8'h7D);
            do_rst();
        end
        wr(8'h0C, 8'hC1);
        @(posedge clk_i);
        halt_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(8'h0C, v);
        repeat (200) @(posedge clk_i);
        rd(8'h0C, w);
        chk(w, v);
        chk({7'h00, sys_reset_n_o}, 8'h01);
        @(posedge clk_i);
        halt_i <= 1'b0;
        wake_irq_i <= 1'b1;
        @(posedge clk_i);
        wake_irq_i <= 1'b0;
        wait_sys(1'b0, n);
        chk({7'h00, n >= 8 && n <= 48}, 8'h01);
        wait_sys(1'b1, n);
        halt_i <= 1'b1;
        do_rst();
        halt_i <= 1'b0;
        rd(8'h0C, v);
        chk(v, 8'h7F);
        summarize();
    end
    // Hang guard, far beyond the expected run length
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule

// ===== sim/wwd_top_monitor.sv
module wwd_top_monitor (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic halt_i,
    input wire logic wake_irq_i,
    input wire logic sys_reset_n_o,
    input wire logic armed_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Low cycles seen so far in the current pulse
    logic [7:0] low_cnt;
    logic [7:0] next_low_cnt;
    // Restart the count whenever the line is high
    always_comb begin
        next_low_cnt = sys_reset_n_o ? 8'h00 : low_cnt + 8'h01;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    a_unmapped_read: assert property ($past(rd_i) && $past(addr_i) != 8'h0C |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_armed_readback: assert property ($past(rd_i) && $past(addr_i) == 8'h0C |-> rdata_o[7] == $past(armed_o))
        else $error("arm bit read wrong");
    a_arm_sticky: assert property (armed_o |=> armed_o)
        else $error("arm cleared");
    a_arm_set: assert property (wr_i && addr_i == 8'h0C && wdata_i[7] |=> armed_o)
        else $error("arm not set");
    a_disarmed_quiet: assert property (!armed_o && !wr_i |=> sys_reset_n_o)
        else $error("reset while disarmed");
    a_forced_reset: assert property (wr_i && addr_i == 8'h0C && (armed_o || wdata_i[7]) && !wdata_i[6]
        && sys_reset_n_o |=> !sys_reset_n_o)
        else $error("forced reset missing");
    a_pulse_width: assert property ($rose(sys_reset_n_o) |-> low_cnt == 8'h7D)
        else $error("pulse width wrong");
    a_pulse_max: assert property (!sys_reset_n_o |-> low_cnt < 8'h7D)
        else $error("pulse too long");
    cover property ($fell(sys_reset_n_o));
    cover property (rd_i && addr_i == 8'h0C);
    cover property ($fell(wake_irq_i));
endmodule
bind wwd_top wwd_top_monitor u_mon (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .halt_i, .wake_irq_i, .sys_reset_n_o, .armed_o);
